// [rtl/sideband_control.sv]
`timescale 1ns/10ps
// Functional notes
// [R1] Answer bus only while select held low.
// [R2] Host gives each module its own select.
// [R3] Serial lines reach the management memory map.
// [R4] Long reset pulse restores all defaults.
// [R5] Host ignores status until reset completes.
// [R6] Completion: attention asserted, not-ready flag cleared.
// [R7] Power-up posts completion without reset pulse.
// [R8] Low-power input caps module power.
// [R9] Presence pin pulls low when inserted.
// [R10] Attention low flags fault or critical status.
// [R11] Host reads status to find cause.
// [R12] Attention only pulls low or releases.
// [R13] Four channels individually disabled through management.
// [R14] Synchronise inputs, filter short reset pulses.
// [R15] Flag positions in map are implementation chosen.
module sideband_control
  import sideband_pkg::*;
#(
  parameter int CHANNELS   = NUM_CHANNELS,
  parameter int RESET_MIN  = RESET_MIN_CYCLES,
  parameter int INIT_DELAY = 16
)
(
  // Clock, reset and freeze.
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  // Host sideband inputs, asynchronous.
  input  wire logic                bus_select_n,
  input  wire logic                module_reset_n,
  input  wire logic                low_power_request,
  // Two-wire bus, open drain.
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  // Presence and attention, open drain.
  output logic                     present_n_out,
  output logic                     present_n_oe,
  output logic                     attention_n_out,
  output logic                     attention_n_oe,
  // Module-internal status and controls.
  input  wire logic                fault_event,
  output logic                     low_power_active,
  output logic [CHANNELS-1:0]      channel_disable,
  output logic                     module_ready
);

  // Parameter sanity: channel bits must fit in one map byte.
  initial begin
    if (CHANNELS < 1 || CHANNELS > 8 || RESET_MIN < 1 || INIT_DELAY < 1) begin
      $error("sideband_control: unsupported parameter values");
    end
  end

  // Width shared by the reset and init counters.
  localparam int CNT_W = $clog2((RESET_MIN > INIT_DELAY ? RESET_MIN : INIT_DELAY) + 2);

  // Block-level state kept as one record.
  typedef struct packed {
    logic [1:0] sel_sy;
    logic [1:0] rst_sy;
    logic [1:0] lp_sy;
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [CNT_W-1:0] rst_cnt;
    logic [CNT_W-1:0] init_cnt;
    logic       initialising;
    logic       not_ready;
    logic       lp;
  } top_t;

  top_t t_reg;   // Registered state.
  top_t t_next;  // Next state.

  // The memory map is a plain byte array held here.
  logic [7:0] map_reg [MAP_DEPTH];

  map_wr_t    wr;        // Write from the serial slave.
  map_rd_t    rd;        // Read pointer advance from the serial slave.
  logic [7:0] rd_data;   // Byte presented to the slave.
  logic       soft_rst;  // Filtered long reset pulse, one cycle.
  logic       done_ev;   // Reset completion event, one cycle.
  logic       selected;  // Synchronised select, active.

  // Reads see the live status byte; everything else comes from the array.
  function automatic logic [7:0] map_view(input logic [ADDR_W-1:0] a,
                                          input logic [7:0] stored,
                                          input logic nr, input logic lp);
    logic [7:0] v;
    v = stored;
    if (a == ADDR_STATUS) begin
      v = 8'h00;
      v[BIT_NOT_READY] = nr;
      v[BIT_LOW_POWER] = lp;
    end
    return v;
  endfunction : map_view

  // Synchronisers, reset filter and the completion sequencer.
  always_comb begin
    t_next        = t_reg;
    // [R14] Two-stage synchronisers.
    t_next.sel_sy = {t_reg.sel_sy[0], bus_select_n};
    t_next.rst_sy = {t_reg.rst_sy[0], module_reset_n};
    t_next.lp_sy  = {t_reg.lp_sy[0], low_power_request};
    t_next.scl_sy = {t_reg.scl_sy[0], scl_in};
    t_next.sda_sy = {t_reg.sda_sy[0], sda_in};
    soft_rst = 1'b0;
    done_ev  = 1'b0;
    // [R14] Reset pulse length filter.
    if (!t_reg.rst_sy[1]) begin
      if (t_reg.rst_cnt != CNT_W'(RESET_MIN)) begin
        t_next.rst_cnt = t_reg.rst_cnt + 1'b1;
      end
      // Pulse soft_rst for one cycle on the RESET_MIN-th sampled low cycle of the reset pin.
      if (t_reg.rst_cnt == CNT_W'(RESET_MIN - 1)) begin
        soft_rst = 1'b1;
      end
    end else begin
      t_next.rst_cnt = '0;
    end
    // [R4] Complete reset restarts initialisation.
    if (soft_rst || (t_reg.rst_cnt == CNT_W'(RESET_MIN) && !t_reg.rst_sy[1])) begin
      t_next.initialising = 1'b1;
      t_next.not_ready    = 1'b1;
      t_next.init_cnt     = '0;
    end else if (t_reg.initialising) begin
      if (t_reg.init_cnt == CNT_W'(INIT_DELAY - 1)) begin
        // [R6] Clear not-ready, post completion.
        t_next.initialising = 1'b0;
        t_next.not_ready    = 1'b0;
        done_ev             = 1'b1;
      end else begin
        t_next.init_cnt = t_reg.init_cnt + 1'b1;
      end
    end
    // [R8] Low-power request follows the pin.
    t_next.lp = t_reg.lp_sy[1];
  end

  // Block register; reset leaves initialisation pending.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      t_reg <= '0;
      t_reg.sel_sy <= 2'b11;
      t_reg.rst_sy <= 2'b11;
      t_reg.scl_sy <= 2'b11;
      t_reg.sda_sy <= 2'b11;
      // [R7] Power-up runs the completion sequence itself.
      t_reg.initialising <= 1'b1;
      t_reg.not_ready    <= 1'b1;
      t_reg.lp           <= 1'b1;
    end else if (clk_en) begin
      t_reg <= t_next;
    end
  end

  // [R1] Select gates all bus answers.
  assign selected = ~t_reg.sel_sy[1];

  // [R3] Serial slave into the map.
  two_wire_slave u_slave (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .scl_s    (t_reg.scl_sy[1]),
    .sda_s    (t_reg.sda_sy[1]),
    .selected (selected),
    .wr       (wr),
    .rd       (rd),
    .rd_data  (rd_data),
    .sda_oe   (sda_oe)
  );

  // Byte offered to the slave at its current pointer.
  assign rd_data = map_view(rd.addr, map_reg[rd.addr], t_reg.not_ready, t_reg.lp);

  // Memory map storage; flags set by hardware beat a clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (clk_en && soft_rst)) begin
      // [R4] Defaults restored.
      for (int i = 0; i < MAP_DEPTH; i++) begin
        map_reg[i] <= MAP_RESET;
      end
    end else if (clk_en) begin
      for (int i = 0; i < MAP_DEPTH; i++) begin
        if (ADDR_W'(i) == ADDR_INT_FLAGS) begin
          // [R11] Write-one-to-clear flags, set wins.
          logic [7:0] f;
          f = map_reg[i];
          if (wr.we && wr.addr == ADDR_INT_FLAGS) begin
            f = f & ~wr.data;
          end
          // [R15] Flag bit positions.
          f[BIT_RESET_DONE] = f[BIT_RESET_DONE] | done_ev;
          // [R10] Fault raises attention.
          f[BIT_FAULT]      = f[BIT_FAULT] | fault_event;
          map_reg[i] <= f;
        end else if (wr.we && wr.addr == ADDR_W'(i) && ADDR_W'(i) != ADDR_STATUS) begin
          map_reg[i] <= wr.data;
        end
      end
    end
  end

  // [R13] Per-channel shutdown from the map.
  assign channel_disable  = map_reg[ADDR_CHAN_OFF][CHANNELS-1:0];
  assign low_power_active = t_reg.lp;
  assign module_ready     = ~t_reg.not_ready;

  // [R9] Presence ties the line low always.
  assign present_n_out = 1'b0;
  assign present_n_oe  = 1'b1;

  // [R12] Open-drain attention and data lines.
  assign attention_n_out = 1'b0;
  assign attention_n_oe  = |map_reg[ADDR_INT_FLAGS];
  assign sda_out         = 1'b0;

endmodule : sideband_control

// [rtl/sideband_pkg.sv]
package sideband_pkg;

  // Number of independent transmit/receive channels.
  localparam int NUM_CHANNELS = 4;

  // Reset pulse filter figures; the least valid low pulse length in ns.
  localparam int SYS_CLK_NS       = 100;
  localparam int RESET_MIN_NS     = 2000;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // Memory map geometry and reset values.
  localparam int  MAP_DEPTH  = 128;
  localparam int  ADDR_W     = 7;
  localparam logic [7:0] MAP_RESET = 8'h00;

  // Status byte address and bit positions inside it.
  localparam logic [6:0] ADDR_STATUS      = 7'h02;
  localparam int         BIT_NOT_READY    = 0;
  localparam int         BIT_LOW_POWER    = 1;
  // Interrupt source flags byte; written with ones to clear.
  localparam logic [6:0] ADDR_INT_FLAGS   = 7'h03;
  localparam int         BIT_RESET_DONE   = 0;
  localparam int         BIT_FAULT        = 1;
  // Per-channel disable byte, one bit per channel in the low nibble.
  localparam logic [6:0] ADDR_CHAN_OFF    = 7'h56;

  // Default device address on the two-wire bus.
  localparam logic [6:0] DEV_ADDR = 7'h50;

  // Phases of the two-wire serial slave.
  typedef enum logic [2:0] {
    TW_IDLE  = 3'b000,
    TW_SHIFT = 3'b001,
    TW_ACK   = 3'b010,
    TW_SEND  = 3'b011,
    TW_MACK  = 3'b100
  } tw_state_t;

  // Write port from the serial slave into the memory map.
  typedef struct packed {
    logic             we;
    logic [ADDR_W-1:0] addr;
    logic [7:0]       data;
  } map_wr_t;

  // Read request from the serial slave (pointer advance on a byte read).
  typedef struct packed {
    logic             re;
    logic [ADDR_W-1:0] addr;
  } map_rd_t;

endpackage : sideband_pkg

// [rtl/two_wire_slave.sv]
`timescale 1ns/10ps
module two_wire_slave
  import sideband_pkg::*;
(
  // Clock, reset and freeze.
  input  wire logic  sys_clk,
  input  wire logic  sys_rst,
  input  wire logic  clk_en,
  // Synchronised bus lines and select.
  input  wire logic  scl_s,
  input  wire logic  sda_s,
  input  wire logic  selected,
  // Memory map access.
  output map_wr_t    wr,
  output map_rd_t    rd,
  input  wire logic [7:0] rd_data,
  // Data line drive, open drain.
  output logic       sda_oe
);

  // All slave state in one record.
  typedef struct packed {
    tw_state_t         st;
    logic              scl_d;
    logic              sda_d;
    logic [7:0]        sh;
    logic [3:0]        cnt;
    logic              is_dev;
    logic              reading;
    logic              have_ptr;
    logic [ADDR_W-1:0] ptr;
    logic              oe;
    map_wr_t           wr;
    map_rd_t           rd;
  } tws_t;

  tws_t s_reg;   // Registered state.
  tws_t s_next;  // Next state.

  logic rise;    // Clock line rising edge.
  logic fall;    // Clock line falling edge.
  logic start;   // Start or repeated start seen.
  logic stop;    // Stop seen.

  // Bus conditions from the registered previous line levels.
  always_comb begin
    rise  = scl_s & ~s_reg.scl_d;
    fall  = ~scl_s & s_reg.scl_d;
    start = scl_s & s_reg.scl_d & s_reg.sda_d & ~sda_s;
    stop  = scl_s & s_reg.scl_d & ~s_reg.sda_d & sda_s;
  end

  // Protocol sequencer; data changes on the falling clock edge, except that a start, stop or deselect releases it at once.
  always_comb begin
    s_next        = s_reg;
    s_next.scl_d  = scl_s;
    s_next.sda_d  = sda_s;
    s_next.wr.we  = 1'b0;
    s_next.rd.re  = 1'b0;
    if (stop || !selected) begin
      // A deselect mid-transfer drops the bus at once so no stray ack appears.
      s_next.st = TW_IDLE;
      s_next.oe = 1'b0;
    end else if (start) begin
      s_next.st  = TW_SHIFT;
      s_next.cnt = 4'h0;
      s_next.is_dev = 1'b1;
      s_next.oe  = 1'b0;
    end else begin
      unique case (s_reg.st)
        TW_IDLE: begin
          s_next.oe = 1'b0;
        end
        TW_SHIFT: begin
          if (rise) begin
            s_next.sh  = {s_reg.sh[6:0], sda_s};
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (fall && s_reg.cnt == 4'h8) begin
            s_next.cnt = 4'h0;
            if (s_reg.is_dev) begin
              // Only our address earns an acknowledge.
              if (s_reg.sh[7:1] == DEV_ADDR) begin
                s_next.reading  = s_reg.sh[0];
                s_next.have_ptr = s_reg.sh[0];
                s_next.oe       = 1'b1;
                s_next.st       = TW_ACK;
              end else begin
                s_next.st = TW_IDLE;
              end
              s_next.is_dev = 1'b0;
            end else begin
              if (!s_reg.have_ptr) begin
                s_next.ptr      = s_reg.sh[ADDR_W-1:0];
                s_next.have_ptr = 1'b1;
              end else begin
                s_next.wr.we   = 1'b1;
                s_next.wr.addr = s_reg.ptr;
                s_next.wr.data = s_reg.sh;
                s_next.ptr     = s_reg.ptr + 1'b1;
              end
              s_next.oe = 1'b1;
              s_next.st = TW_ACK;
            end
          end
        end
        TW_ACK: begin
          if (fall) begin
            if (s_reg.reading) begin
              s_next.sh    = rd_data;
              s_next.rd.re = 1'b1;
              s_next.rd.addr = s_reg.ptr;
              s_next.ptr   = s_reg.ptr + 1'b1;
              s_next.oe    = ~rd_data[7];
              s_next.cnt   = 4'h1;
              s_next.st    = TW_SEND;
            end else begin
              s_next.oe = 1'b0;
              s_next.st = TW_SHIFT;
            end
          end
        end
        TW_SEND: begin
          if (fall) begin
            if (s_reg.cnt == 4'h8) begin
              s_next.oe = 1'b0;
              s_next.st = TW_MACK;
            end else begin
              s_next.oe  = ~s_reg.sh[3'(7 - s_reg.cnt)];
              s_next.cnt = s_reg.cnt + 4'h1;
            end
          end
        end
        TW_MACK: begin
          // Host ack asks for another byte; a nack ends the read.
          if (rise) begin
            s_next.st = sda_s ? TW_IDLE : TW_ACK;
          end
        end
        default: begin
          s_next.st = TW_IDLE;
        end
      endcase
    end
  end

  // State register with synchronous reset and clock enable.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.scl_d <= 1'b1;
      s_reg.sda_d <= 1'b1;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign wr     = s_reg.wr;
  // The read address always shows the live pointer, so the byte offered for the next
  // send is the one the host addressed, not the one fetched by the previous read.
  assign rd     = '{re: s_reg.rd.re, addr: s_reg.ptr};
  assign sda_oe = s_reg.oe;

endmodule : two_wire_slave

// [testbench/sideband_control_checker.sv]
`timescale 1ns/10ps
module sideband_control_checker
  import sideband_pkg::*;
#(
  parameter int CHANNELS   = NUM_CHANNELS,
  parameter int RESET_MIN  = RESET_MIN_CYCLES,
  parameter int INIT_DELAY = 16
)
(
  // Clock and reset.
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  // Host sideband inputs and the module fault input.
  input wire logic                bus_select_n,
  input wire logic                module_reset_n,
  input wire logic                low_power_request,
  input wire logic                fault_event,
  // Outputs of the block.
  input wire logic                sda_oe,
  input wire logic                present_n_out,
  input wire logic                present_n_oe,
  input wire logic                attention_n_out,
  input wire logic                attention_n_oe,
  input wire logic                low_power_active,
  input wire logic [CHANNELS-1:0] channel_disable,
  input wire logic                module_ready
);
  // Slack covers the two-flop synchronisers and the output register.
  localparam int INIT_LIM = INIT_DELAY + 6;
  localparam int HOLD_LIM = RESET_MIN + 4;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Counts sampled low cycles of the reset pin; it saturates so it never wraps.
  int unsigned low_cnt_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || module_reset_n) begin
      low_cnt_reg <= 0;
    end else if (low_cnt_reg < 1000) begin
      low_cnt_reg <= low_cnt_reg + 1;
    end
  end

  // A pin pulse well below the minimum, starting from a ready module.
  sequence short_low;
    module_ready && module_reset_n ##1 (!module_reset_n) [*2] ##1 module_reset_n;
  endsequence

  AST_DESELECT_QUIET: assert property (
    bus_select_n [*5] |-> !sda_oe) else $error("data line driven while deselected");
  AST_PIN_RESET_DEFAULTS: assert property (
    (low_cnt_reg >= HOLD_LIM) && module_reset_n |-> ##[0:4] (channel_disable == '0))
    else $error("long reset pulse kept channel settings");
  AST_READY_WITH_ATTENTION: assert property (
    $rose(module_ready) |-> ##[0:1] attention_n_oe) else $error("ready without attention");
  AST_POWER_UP_READY: assert property (
    $fell(sys_rst) |-> ##[1:INIT_LIM] module_ready) else $error("no completion after power-up");
  AST_LOW_POWER_ON: assert property (
    low_power_request [*5] |-> low_power_active) else $error("low power not applied");
  AST_LOW_POWER_OFF: assert property (
    (!low_power_request) [*5] |-> !low_power_active) else $error("low power not lifted");
  AST_PRESENT_LOW: assert property (
    present_n_oe && !present_n_out) else $error("presence pin not pulled low");
  AST_FAULT_ATTENTION: assert property (
    fault_event && module_ready && module_reset_n |-> ##[1:2] attention_n_oe)
    else $error("fault did not raise attention");
  AST_ATTENTION_PULL_ONLY: assert property (
    !attention_n_out) else $error("attention pin driven high");
  AST_SHORT_PULSE_FILTERED: assert property (
    short_low |-> module_ready [*6]) else $error("short reset pulse was taken");
endmodule : sideband_control_checker

bind sideband_control sideband_control_checker #(
  .CHANNELS(CHANNELS), .RESET_MIN(RESET_MIN), .INIT_DELAY(INIT_DELAY)
) chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_select_n(bus_select_n),
  .module_reset_n(module_reset_n), .low_power_request(low_power_request),
  .fault_event(fault_event), .sda_oe(sda_oe), .present_n_out(present_n_out),
  .present_n_oe(present_n_oe), .attention_n_out(attention_n_out),
  .attention_n_oe(attention_n_oe), .low_power_active(low_power_active),
  .channel_disable(channel_disable), .module_ready(module_ready)
);

// [testbench/host_board_model.sv]
`timescale 1ns/10ps
module host_board_model (
  // Open-drain enables from the module.
  input  wire logic sda_oe,
  input  wire logic attention_n_oe,
  input  wire logic present_n_oe,
  // Resolved line levels.
  output logic      scl,
  output logic      sda,
  output logic      attention_line,
  output logic      present_line
);
  // Host drive: high pulls the line to ground.
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;

  // host pull-ups
  // A released line reads high, never its last driven value.
  assign scl = !scl_low;
  assign sda = !(sda_low || sda_oe);
  assign attention_line = !attention_n_oe;
  assign present_line = !present_n_oe;

  // One bit slot of 800 ns; data moves only while the clock is low.
  task automatic bit_io(input logic b, output logic seen);
    #200 sda_low = !b;
    #200 scl_low = 1'b0;
    #200 seen = sda;
    #200 scl_low = 1'b1;
  endtask : bit_io

  // Start or repeated start; the long second wait, before the clock rises, lets a slave ack run out.
  task automatic start_cond();
    #200 sda_low = 1'b0;
    #400 scl_low = 1'b0;
    #200 sda_low = 1'b1;
    #200 scl_low = 1'b1;
  endtask : start_cond

  // Stop: data rises while the clock is high.
  task automatic stop_cond();
    sda_low = 1'b1;
    #200 scl_low = 1'b0;
    #200 sda_low = 1'b0;
    #200;
  endtask : stop_cond

  // Byte out, most significant bit first, then the slave's ack slot.
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(v[i], s);
    bit_io(1'b1, ack);
  endtask : send_byte

  // Byte in; the host answers with a nack so the read ends here.
  task automatic recv_byte(output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(1'b1, s);
  endtask : recv_byte
endmodule : host_board_model

// [testbench/sideband_control_bench.sv]
`timescale 1ns/10ps
module sideband_control_bench
  import sideband_pkg::*;
;
  // Stimulus and observed signals.
  logic                    sys_clk = 1'b0;
  logic                    sys_rst, clk_en, bus_select_n, module_reset_n;
  logic                    low_power_request, fault_event;
  logic                    scl, sda, attention_line, present_line;
  logic                    sda_oe, present_n_oe, attention_n_oe;
  logic                    low_power_active, module_ready;
  logic [NUM_CHANNELS-1:0] channel_disable;
  int                      num_errors = 0;
  int                      compares = 0;

  // Clock at 10 MHz.
  always #50 sys_clk = ~sys_clk;

  // Counts are shortened so the run stays brief.
  sideband_control #(.RESET_MIN(4), .INIT_DELAY(4)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus_select_n(bus_select_n),
    .module_reset_n(module_reset_n), .low_power_request(low_power_request),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .present_n_out(),
    .present_n_oe(present_n_oe), .attention_n_out(), .attention_n_oe(attention_n_oe),
    .fault_event(fault_event), .low_power_active(low_power_active),
    .channel_disable(channel_disable), .module_ready(module_ready));

  host_board_model host (
    .sda_oe(sda_oe), .attention_n_oe(attention_n_oe), .present_n_oe(present_n_oe),
    .scl(scl), .sda(sda), .attention_line(attention_line), .present_line(present_line));

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // Pointer write then one data byte; acks come back as three bits.
  task automatic map_write(input logic [6:0] a, input logic [7:0] d, output logic [2:0] k);
    host.start_cond();
    host.send_byte({DEV_ADDR, 1'b0}, k[2]);
    host.send_byte({1'b0, a}, k[1]);
    host.send_byte(d, k[0]);
    host.stop_cond();
  endtask : map_write

  // Pointer write, repeated start, one byte read.
  task automatic map_read(input logic [6:0] a, output logic [7:0] d);
    logic k;
    host.start_cond();
    host.send_byte({DEV_ADDR, 1'b0}, k);
    host.send_byte({1'b0, a}, k);
    host.start_cond();
    host.send_byte({DEV_ADDR, 1'b1}, k);
    host.recv_byte(d);
    host.stop_cond();
  endtask : map_read

  // Bounded wait for completion, then checks it came.
  task automatic wait_ready();
    for (int i = 0; i < 200 && module_ready !== 1'b1; i++) @(posedge sys_clk);
    #1 check("ready", {7'h0, module_ready}, 8'h01);
  endtask : wait_ready

  // Main sequence; inputs move 1 ns after a rising edge.
  initial begin
    logic [7:0] rd;
    logic [2:0] acks;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    bus_select_n = 1'b0;
    module_reset_n = 1'b1;
    low_power_request = 1'b0;
    fault_event = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    wait_ready();
    check("present", {7'h0, present_line}, 8'h00);
    check("attention", {7'h0, attention_line}, 8'h00);
    map_read(ADDR_STATUS, rd);
    check("status", rd, 8'h00);
    map_read(ADDR_INT_FLAGS, rd);
    check("flags", rd, 8'h01);
    map_write(ADDR_INT_FLAGS, 8'h01, acks);
    check("acks", {5'h0, acks}, 8'h00);
    check("attention", {7'h0, attention_line}, 8'h01);
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      map_write(ADDR_CHAN_OFF, 8'h01 << i, acks);
      check("channels", {4'h0, channel_disable}, 8'h01 << i);
      map_read(ADDR_CHAN_OFF, rd);
      check("channel byte", rd, 8'h01 << i);
    end
    // A deselected module must leave the bus alone.
    bus_select_n = 1'b1;
    map_write(ADDR_CHAN_OFF, 8'h0F, acks);
    bus_select_n = 1'b0;
    check("deselect acks", {5'h0, acks}, 8'h07);
    check("channels", {4'h0, channel_disable}, 8'h08);
    low_power_request = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 check("low power", {7'h0, low_power_active}, 8'h01);
    map_read(ADDR_STATUS, rd);
    low_power_request = 1'b0;
    check("status", rd, 8'h02);
    fault_event = 1'b1;
    @(posedge sys_clk);
    #1 fault_event = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 check("attention", {7'h0, attention_line}, 8'h00);
    map_read(ADDR_INT_FLAGS, rd);
    check("flags", rd, 8'h02);
    map_write(ADDR_INT_FLAGS, 8'h02, acks);
    check("attention", {7'h0, attention_line}, 8'h01);
    // A pulse shorter than the minimum is filtered, a long one resets.
    module_reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 module_reset_n = 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 check("channels", {4'h0, channel_disable}, 8'h08);
    module_reset_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 module_reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 check("channels", {4'h0, channel_disable}, 8'h00);
    wait_ready();
    check("attention", {7'h0, attention_line}, 8'h00);
    map_read(ADDR_INT_FLAGS, rd);
    check("flags", rd, 8'h01);
    summarize();
  end

  // Watchdog well past the expected few thousand cycles.
  initial begin
    repeat (50000) @(posedge sys_clk);
    num_errors++;
    summarize();
  end
endmodule : sideband_control_bench
